/* File: ptw_pkg.sv */
// package: register map, field layout, reset values and timing for the tick and watchdog block
package ptw_pkg;
  localparam logic [7:0] TICK_CTRL_ADDR = 8'h14;
  localparam logic [7:0] TICK_FLAG_ADDR = 8'h15;
  localparam logic [7:0] WDG_CTRL_ADDR = 8'h16;
  localparam logic [7:0] WDG_SERVICE_ADDR = 8'h17;
  // tick control bits
  localparam int TC_IE_BIT = 7;
  localparam int TC_WAIT_BIT = 6;
  localparam int TC_BDM_BIT = 5;
  localparam int TC_BYP_BIT = 4;
  localparam int TC_RATE_LSB = 0;
  // tick flag bit
  localparam int TF_FLAG_BIT = 7;
  // watchdog control bits
  localparam int WC_CME_BIT = 7;
  localparam int WC_FORCE_MONITOR_BIT = 6;
  localparam int WC_FRC_BIT = 5;
  localparam int WC_WIN_BIT = 4;
  localparam int WC_DIS_BIT = 3;
  localparam int WC_RATE_LSB = 0;
  localparam logic [7:0] TICK_CTRL_RESET = 8'h00;
  localparam logic [7:0] WDG_CTRL_RESET_NORMAL = 8'h07;
  localparam logic [7:0] WDG_CTRL_RESET_SPECIAL = 8'h0F;
  localparam logic [7:0] KEY_ARM = 8'h55;
  localparam logic [7:0] KEY_FIRE = 8'hAA;
  // divider chain: first stage is 2^13, bypass replaces it with 4
  localparam int PRESCALE_LOG2 = 13;
  localparam int BYPASS_LOG2 = 2;
  localparam int CHAIN_WIDTH = 11;
  localparam int WDG_CNT_WIDTH = 11;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ptw_bus_t;
endpackage

/* File: ptw_top.sv */
// tick and watchdog block: divider chain, periodic tick, watchdog, clock monitor reset controls
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
module ptw_top #(
  parameter int WDG_WIDTH = ptw_pkg::WDG_CNT_WIDTH
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic tick_clk_en,
  input wire logic special_mode,
  input wire logic in_background,
  input wire logic in_wait,
  input wire logic clock_lost,
  input wire logic monitor_enable_strap,
  input wire ptw_pkg::ptw_bus_t bus,
  output logic [7:0] rdata,
  output logic tick_irq,
  output logic wdg_reset,
  output logic monitor_reset,
  output logic monitor_active
);

  ////////////////////////////////////////////////////////////////////////
  // registers and decode

  logic [7:0] tick_ctrl_reg;
  logic [7:0] wdg_ctrl_reg;
  logic tick_flag_reg;
  logic strap_done_reg;
  logic bdm_once_reg;
  logic wait_once_reg;
  logic force_monitor_once_reg;
  logic win_once_reg;
  logic rate_once_reg;
  logic [7:0] rdata_reg;

  function automatic logic hit(input ptw_pkg::ptw_bus_t b, input logic [7:0] a);
    hit = b.wr && (b.addr == a);
  endfunction

  logic wr_tc;
  logic wr_tf;
  logic wr_wc;
  logic wr_ws;
  assign wr_tc = hit(bus, ptw_pkg::TICK_CTRL_ADDR);
  assign wr_tf = hit(bus, ptw_pkg::TICK_FLAG_ADDR);
  assign wr_wc = hit(bus, ptw_pkg::WDG_CTRL_ADDR);
  assign wr_ws = hit(bus, ptw_pkg::WDG_SERVICE_ADDR);

  // tick control: enable and rate free, the rest write-once or special-only
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      tick_ctrl_reg <= ptw_pkg::TICK_CTRL_RESET;
      bdm_once_reg <= 1'b0;
      wait_once_reg <= 1'b0;
    end
    else if (wr_tc)
    begin
      tick_ctrl_reg[ptw_pkg::TC_IE_BIT] <= bus.wdata[ptw_pkg::TC_IE_BIT];
      tick_ctrl_reg[ptw_pkg::TC_RATE_LSB +: 3] <= bus.wdata[ptw_pkg::TC_RATE_LSB +: 3];
      if (special_mode || !bdm_once_reg)
        tick_ctrl_reg[ptw_pkg::TC_BDM_BIT] <= bus.wdata[ptw_pkg::TC_BDM_BIT];
      if (special_mode || !wait_once_reg)
        tick_ctrl_reg[ptw_pkg::TC_WAIT_BIT] <= bus.wdata[ptw_pkg::TC_WAIT_BIT];
      if (special_mode)
        tick_ctrl_reg[ptw_pkg::TC_BYP_BIT] <= bus.wdata[ptw_pkg::TC_BYP_BIT];
      bdm_once_reg <= 1'b1;
      wait_once_reg <= 1'b1;
    end
  end

  // watchdog control; mode-dependent reset value taken on first clock after release
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      wdg_ctrl_reg <= ptw_pkg::WDG_CTRL_RESET_NORMAL;
      strap_done_reg <= 1'b0;
      force_monitor_once_reg <= 1'b0;
      win_once_reg <= 1'b0;
      rate_once_reg <= 1'b0;
    end
    else if (!strap_done_reg)
    begin
      strap_done_reg <= 1'b1;
      wdg_ctrl_reg <= special_mode ? ptw_pkg::WDG_CTRL_RESET_SPECIAL
                                   : ptw_pkg::WDG_CTRL_RESET_NORMAL;
      wdg_ctrl_reg[ptw_pkg::WC_CME_BIT] <= monitor_enable_strap;
    end
    else
    begin
      // force-reset test is a one-shot strobe bit
      wdg_ctrl_reg[ptw_pkg::WC_FRC_BIT] <= 1'b0;
      if (wr_wc)
      begin
        wdg_ctrl_reg[ptw_pkg::WC_CME_BIT] <= bus.wdata[ptw_pkg::WC_CME_BIT];
        if (special_mode || !force_monitor_once_reg)
          wdg_ctrl_reg[ptw_pkg::WC_FORCE_MONITOR_BIT] <= bus.wdata[ptw_pkg::WC_FORCE_MONITOR_BIT];
        if (special_mode || !win_once_reg)
          wdg_ctrl_reg[ptw_pkg::WC_WIN_BIT] <= bus.wdata[ptw_pkg::WC_WIN_BIT];
        if (special_mode || !rate_once_reg)
          wdg_ctrl_reg[ptw_pkg::WC_RATE_LSB +: 3] <= bus.wdata[ptw_pkg::WC_RATE_LSB +: 3];
        if (special_mode)
        begin
          wdg_ctrl_reg[ptw_pkg::WC_DIS_BIT] <= bus.wdata[ptw_pkg::WC_DIS_BIT];
          wdg_ctrl_reg[ptw_pkg::WC_FRC_BIT] <= bus.wdata[ptw_pkg::WC_FRC_BIT];
        end
        force_monitor_once_reg <= 1'b1;
        win_once_reg <= 1'b1;
        rate_once_reg <= 1'b1;
      end
    end
  end

  logic tick_ie;
  logic bdm_stop;
  logic wait_stop;
  logic bypass;
  logic [2:0] tick_rate;
  logic monitor_enable;
  logic force_monitor;
  logic force_test;
  logic win_mode;
  logic rst_dis;
  logic [2:0] wdg_rate;
  assign tick_ie = tick_ctrl_reg[ptw_pkg::TC_IE_BIT];
  assign wait_stop = tick_ctrl_reg[ptw_pkg::TC_WAIT_BIT];
  assign bdm_stop = tick_ctrl_reg[ptw_pkg::TC_BDM_BIT];
  assign bypass = tick_ctrl_reg[ptw_pkg::TC_BYP_BIT];
  assign tick_rate = tick_ctrl_reg[ptw_pkg::TC_RATE_LSB +: 3];
  assign monitor_enable = wdg_ctrl_reg[ptw_pkg::WC_CME_BIT];
  assign force_monitor = wdg_ctrl_reg[ptw_pkg::WC_FORCE_MONITOR_BIT];
  assign force_test = wdg_ctrl_reg[ptw_pkg::WC_FRC_BIT];
  assign win_mode = wdg_ctrl_reg[ptw_pkg::WC_WIN_BIT];
  assign rst_dis = wdg_ctrl_reg[ptw_pkg::WC_DIS_BIT];
  assign wdg_rate = wdg_ctrl_reg[ptw_pkg::WC_RATE_LSB +: 3];

  ////////////////////////////////////////////////////////////////////////
  // divider chain

  logic halted;
  logic advance;
  assign halted = (bdm_stop && in_background) || (wait_stop && in_wait);
  assign advance = tick_clk_en && !halted;

  logic [ptw_pkg::PRESCALE_LOG2-1:0] pre_reg;
  logic pre_out;
  // prescale free-runs; a watchdog restart never touches it
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      pre_reg <= '0;
    else if (advance)
      pre_reg <= pre_reg + 1'b1;
  end
  assign pre_out = advance && (bypass ? (&pre_reg[ptw_pkg::BYPASS_LOG2-1:0]) : (&pre_reg));

  logic [ptw_pkg::CHAIN_WIDTH-1:0] chain_reg;
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      chain_reg <= '0;
    else if (pre_out)
      chain_reg <= chain_reg + 1'b1;
  end

  // tick period for code c is 2^(12+c): prescale plus c-1 chain bits
  function automatic logic chain_done(input logic [ptw_pkg::CHAIN_WIDTH-1:0] c,
                                      input logic [3:0] n);
    logic r;
    r = 1'b1;
    for (int i = 0; i < ptw_pkg::CHAIN_WIDTH; i++)
      if (i < n)
        r = r & c[i];
    chain_done = r;
  endfunction

  logic tick_evt;
  assign tick_evt = pre_out && (tick_rate != 3'd0) &&
                    chain_done(chain_reg, {1'b0, tick_rate} - 4'd1);

  ////////////////////////////////////////////////////////////////////////
  // tick flag and request

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      tick_flag_reg <= 1'b0;
    else if (tick_evt)
      tick_flag_reg <= 1'b1;
    else if (wr_tf && bus.wdata[ptw_pkg::TF_FLAG_BIT])
      tick_flag_reg <= 1'b0;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      tick_irq <= 1'b0;
    else
      tick_irq <= tick_flag_reg && tick_ie;
  end

  ////////////////////////////////////////////////////////////////////////
  // watchdog counter, counts prescale outputs since last restart

  function automatic logic [4:0] wdg_bits(input logic [2:0] r);
    case (r)
      3'd1: wdg_bits = 5'd0;
      3'd2: wdg_bits = 5'd2;
      3'd3: wdg_bits = 5'd4;
      3'd4: wdg_bits = 5'd6;
      3'd5: wdg_bits = 5'd8;
      3'd6: wdg_bits = 5'd9;
      3'd7: wdg_bits = 5'd10;
      default: wdg_bits = 5'd0;
    endcase
  endfunction

  logic [WDG_WIDTH-1:0] wdg_cnt_reg;
  logic [WDG_WIDTH:0] wdg_limit;
  logic [WDG_WIDTH:0] wdg_wopen;
  logic wdg_on;
  logic wdg_timeout;
  logic in_window;
  logic restart;
  logic key_arm;
  logic key_fire;
  logic bad_key;
  logic early;
  assign wdg_on = (wdg_rate != 3'd0);
  assign wdg_limit = (WDG_WIDTH+1)'(1) << wdg_bits(wdg_rate);
  // window opens after three quarters of the period
  assign wdg_wopen = wdg_limit - (wdg_limit >> 2);
  assign in_window = ({1'b0, wdg_cnt_reg} >= wdg_wopen);
  assign wdg_timeout = wdg_on && pre_out &&
                       ({1'b0, wdg_cnt_reg} + 1'b1 >= wdg_limit);
  assign key_arm = wr_ws && (bus.wdata == ptw_pkg::KEY_ARM);
  assign key_fire = wr_ws && (bus.wdata == ptw_pkg::KEY_FIRE);
  assign bad_key = wdg_on && wr_ws && !key_arm && !key_fire;
  assign early = wdg_on && win_mode && wr_ws && !in_window;

  logic armed_reg;
  assign restart = key_fire && armed_reg;
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      armed_reg <= 1'b0;
    else if (restart)
      armed_reg <= 1'b0;
    else if (key_arm)
      armed_reg <= 1'b1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      wdg_cnt_reg <= '0;
    else if (restart || !wdg_on || wdg_timeout)
      wdg_cnt_reg <= '0;
    else if (pre_out)
      wdg_cnt_reg <= wdg_cnt_reg + 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // reset requests

  logic mon_on;
  logic wdg_fail;
  logic mon_fail;
  assign mon_on = force_monitor || monitor_enable;
  assign wdg_fail = wdg_timeout || bad_key || early || (force_test && wdg_on);
  assign mon_fail = (mon_on && clock_lost) || (force_test && mon_on);

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      wdg_reset <= 1'b0;
      monitor_reset <= 1'b0;
      monitor_active <= 1'b0;
    end
    else
    begin
      // clock monitor vector outranks watchdog when both fire
      monitor_reset <= !rst_dis && mon_fail;
      wdg_reset <= !rst_dis && wdg_fail && !mon_fail;
      monitor_active <= mon_on;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      rdata_reg <= 8'h00;
    else if (bus.rd)
    begin
      case (bus.addr)
        ptw_pkg::TICK_CTRL_ADDR: rdata_reg <= tick_ctrl_reg;
        ptw_pkg::TICK_FLAG_ADDR: rdata_reg <= {tick_flag_reg, 7'h00};
        ptw_pkg::WDG_CTRL_ADDR: rdata_reg <= wdg_ctrl_reg;
        default: rdata_reg <= 8'h00;
      endcase
    end
    else
      rdata_reg <= 8'h00;
  end
  assign rdata = rdata_reg;

  ////////////////////////////////////////////////////////////////////////
  // checks

  property p_flag_clear;
    @(posedge ref_clk) disable iff (!rst_n)
      (wr_tf && bus.wdata[ptw_pkg::TF_FLAG_BIT] && !tick_evt) |=> !tick_flag_reg;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

  property p_flag_set;
    @(posedge ref_clk) disable iff (!rst_n) tick_evt |=> tick_flag_reg;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("tick flag lost");

  property p_irq;
    @(posedge ref_clk) disable iff (!rst_n)
      (tick_flag_reg && tick_ie) |=> tick_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("tick request missing");

  property p_no_irq;
    @(posedge ref_clk) disable iff (!rst_n) !tick_ie |=> !tick_irq;
  endproperty
  a_no_irq: assert property (p_no_irq) else $error("tick request while disabled");

  property p_halt;
    @(posedge ref_clk) disable iff (!rst_n) halted |=> $stable(pre_reg);
  endproperty
  a_halt: assert property (p_halt) else $error("counting while halted");

  property p_disable;
    @(posedge ref_clk) disable iff (!rst_n)
      rst_dis |=> !wdg_reset && !monitor_reset;
  endproperty
  a_disable: assert property (p_disable) else $error("reset while disabled");

  property p_bad_key;
    @(posedge ref_clk) disable iff (!rst_n)
      (bad_key && !rst_dis && !mon_fail) |=> wdg_reset;
  endproperty
  a_bad_key: assert property (p_bad_key) else $error("bad key ignored");

  property p_priority;
    @(posedge ref_clk) disable iff (!rst_n) !(wdg_reset && monitor_reset);
  endproperty
  a_priority: assert property (p_priority) else $error("two failure vectors");

  sequence s_bypass_write;
    wr_tc && !special_mode && (bus.wdata[ptw_pkg::TC_BYP_BIT] != bypass);
  endsequence
  property p_bypass_lock;
    @(posedge ref_clk) disable iff (!rst_n) s_bypass_write |=> $stable(bypass);
  endproperty
  a_bypass_lock: assert property (p_bypass_lock) else $error("bypass written in normal");

  property p_force;
    @(posedge ref_clk) disable iff (!rst_n) force_monitor |=> monitor_active;
  endproperty
  a_force: assert property (p_force) else $error("forced monitor inactive");
endmodule

/* File: tb_top.sv */
// self-checking bench for the tick and watchdog block
`timescale 1ns/1ps
module tb_top;
  logic ref_clk;
  logic rst_n;
  logic tick_clk_en;
  logic special_mode;
  logic in_background;
  logic in_wait;
  logic clock_lost;
  logic strap;
  ptw_pkg::ptw_bus_t bus;
  logic [7:0] rdata;
  logic tick_irq;
  logic wdg_reset;
  logic monitor_reset;
  logic monitor_active;
  int bad_count;
  int comparisons;
  int cyc;
  int wdg_cnt;
  int mon_cnt;
  int seed;
  int t0;
  int t1;
  int cw;
  int cm;
  logic [31:0] rnd;
  logic [7:0] bad;
  logic [7:0] exp_q[$];
  logic rd_d;
  logic mon_d;

  ptw_top u_ptw_top (.ref_clk(ref_clk), .rst_n(rst_n), .tick_clk_en(tick_clk_en),
    .special_mode(special_mode), .in_background(in_background), .in_wait(in_wait),
    .clock_lost(clock_lost), .monitor_enable_strap(strap), .bus(bus), .rdata(rdata),
    .tick_irq(tick_irq), .wdg_reset(wdg_reset), .monitor_reset(monitor_reset),
    .monitor_active(monitor_active));

  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  //////////////////////////////////////////////////////////////////////////////
  task check(input logic [15:0] e, input logic [15:0] g, input string nm);
    comparisons++;
    if (g !== e)
    begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task final_report;
    if (bad_count == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // read data stands only in the cycle after the strobe, so it is taken right there
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (wdg_reset === 1'b1)
      wdg_cnt <= wdg_cnt + 1;
    if (monitor_reset === 1'b1 && mon_d !== 1'b1)
      mon_cnt <= mon_cnt + 1;
    mon_d <= monitor_reset;
    if (rd_d)
      check(exp_q.pop_front(), rdata, "rdata");
    rd_d <= bus.rd;
  end
  //////////////////////////////////////////////////////////////////////////////
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus <= '0;
  endtask

  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    exp_q.push_back(e);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus <= '0;
  endtask

  task svc;
    wr(8'h17, 8'h55);
    wr(8'h17, 8'hAA);
  endtask

  task do_reset(input logic sp, input logic st);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    special_mode <= sp;
    strap <= st;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
  endtask

  task wait_irq(output int t);
    int n;
    n = 0;
    while (tick_irq !== 1'b1 && n < 2000)
    begin
      @(negedge ref_clk);
      n++;
    end
    t = cyc;
  endtask

  task lose_clock(input int c0, input int inc);
    clock_lost <= 1'b1;
    repeat (4) @(posedge ref_clk);
    clock_lost <= 1'b0;
    repeat (2) @(posedge ref_clk);
    check(16'(inc), 16'(mon_cnt - c0), "monitor_reset count");
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst_n = 1'b0;
    tick_clk_en = 1'b1;
    special_mode = 1'b0;
    in_background = 1'b0;
    in_wait = 1'b0;
    clock_lost = 1'b0;
    strap = 1'b1;
    bus = '0;
    rd_d = 1'b0;
    mon_d = 1'b0;
    seed = 50797;
    rnd = $random(seed);
    bad = {1'b0, rnd[6:1], 1'b0};
    do_reset(1'b0, 1'b1);
    rd(8'h14, 8'h00);
    rd(8'h15, 8'h00);
    rd(8'h16, 8'h87);
    rd(8'h20 | {3'b000, rnd[12:8]}, 8'h00);
    wr(8'h14, 8'h31);
    rd(8'h14, 8'h21);
    wr(8'h14, 8'h83);
    rd(8'h14, 8'hA3);
    wr(8'h16, 8'h6C);
    wr(8'h16, 8'h01);
    rd(8'h16, 8'h44);
    check(1, monitor_active, "monitor_active");
    lose_clock(mon_cnt, 1);
    // special mode from here: bypass gives short prescale periods of 4 ticks
    do_reset(1'b1, 1'b0);
    rd(8'h16, 8'h0F);
    wr(8'h16, 8'h03);
    check(0, monitor_active, "monitor_active");
    lose_clock(mon_cnt, 0);
    wr(8'h16, 8'h4B);
    lose_clock(mon_cnt, 0);
    wr(8'h16, 8'h43);
    lose_clock(mon_cnt, 1);
    wr(8'h16, 8'h0F);
    for (int c = 3; c <= 7; c++)
    begin
      wr(8'h14, 8'h90 | 8'(c));
      wait_irq(t0);
      wr(8'h15, 8'h80);
      repeat (2) @(posedge ref_clk);
      wait_irq(t0);
      wr(8'h15, 8'h00);
      rd(8'h15, 8'h80);
      wr(8'h15, 8'h80);
      repeat (2) @(posedge ref_clk);
      wait_irq(t1);
      check(16'(4 << (c - 1)), 16'(t1 - t0), "tick period");
    end
    wr(8'h14, 8'h90);
    wr(8'h15, 8'h80);
    repeat (300) @(posedge ref_clk);
    check(0, tick_irq, "tick_irq off");
    wr(8'h14, 8'h13);
    repeat (40) @(posedge ref_clk);
    check(0, tick_irq, "tick_irq masked");
    rd(8'h15, 8'h80);
    for (int k = 0; k < 2; k++)
    begin
      wr(8'h14, (k == 0) ? 8'h33 : 8'h53);
      wr(8'h16, 8'h03);
      svc();
      in_background <= (k == 0);
      in_wait <= (k == 1);
      repeat (3) @(posedge ref_clk);
      wr(8'h15, 8'h80);
      cw = wdg_cnt;
      repeat (150) @(posedge ref_clk);
      rd(8'h15, 8'h00);
      check(16'(cw), 16'(wdg_cnt), "halted watchdog");
      in_background <= 1'b0;
      in_wait <= 1'b0;
      repeat (40) @(posedge ref_clk);
      rd(8'h15, 8'h80);
    end
    wr(8'h14, 8'h10);
    wr(8'h16, 8'h03);
    svc();
    cw = wdg_cnt;
    t0 = cyc;
    repeat (6)
    begin
      repeat (30) @(posedge ref_clk);
      svc();
    end
    check(16'(cw), 16'(wdg_cnt), "serviced watchdog");
    t0 = cyc;
    while (wdg_cnt == cw && cyc - t0 < 300)
      @(negedge ref_clk);
    check(1, 16'((cyc - t0) >= 58 && (cyc - t0) <= 72), "timeout span");
    wr(8'h16, 8'h03);
    svc();
    cw = wdg_cnt;
    wr(8'h17, bad);
    repeat (3) @(posedge ref_clk);
    check(16'(cw + 1), 16'(wdg_cnt), "bad key reset");
    rd(8'h17, 8'h00);
    wr(8'h16, 8'h0B);
    cw = wdg_cnt;
    wr(8'h17, bad);
    repeat (100) @(posedge ref_clk);
    check(16'(cw), 16'(wdg_cnt), "disabled reset");
    // rate 4 keeps the window far from the prescale uncertainty
    wr(8'h16, 8'h04);
    svc();
    wr(8'h16, 8'h14);
    cw = wdg_cnt;
    repeat (204) @(posedge ref_clk);
    wr(8'h17, 8'h55);
    wr(8'h17, 8'h55);
    svc();
    repeat (2) @(posedge ref_clk);
    check(16'(cw), 16'(wdg_cnt), "window service");
    wr(8'h17, 8'h55);
    repeat (3) @(posedge ref_clk);
    check(16'(cw + 1), 16'(wdg_cnt), "early write reset");
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h16, (i[1] ? 8'h80 : 8'h00) | (i[0] ? 8'h03 : 8'h00));
      svc();
      cw = wdg_cnt;
      cm = mon_cnt;
      wr(8'h16, (i[1] ? 8'hA0 : 8'h20) | (i[0] ? 8'h03 : 8'h00));
      repeat (4) @(posedge ref_clk);
      check(16'(i == 1), 16'(wdg_cnt - cw), "forced watchdog");
      check(16'(i[1]), 16'(mon_cnt - cm), "forced monitor");
    end
    repeat (3) @(posedge ref_clk);
    final_report();
  end

  // the whole run takes under 12000 cycles
  initial
  begin
    repeat (60000) @(posedge ref_clk);
    bad_count++;
    final_report();
  end
endmodule
